// >>> hw/urx_pkg.sv
// Purpose: constants for the serial receive block (status, buffer, start detect)
// Assumes: one 100 MHz clock, plain register port with read data one cycle late
package urx_pkg;
   localparam logic [2:0] ADDR_STATUS_A = 3'h0;
   localparam logic [2:0] ADDR_CONTROL_B = 3'h1;
   localparam logic [2:0] ADDR_FORMAT_C = 3'h2;
   localparam logic [2:0] ADDR_DATA = 3'h3;
   localparam logic [2:0] ADDR_BAUD = 3'h4;
   // status a fields
   localparam int ST_RXC = 7;
   localparam int ST_FE = 4;
   localparam int ST_DOR = 3;
   localparam int ST_UPE = 2;
   localparam int ST_U2X = 1;
   // control b fields
   localparam int CB_RXCIE = 7;
   localparam int CB_RXEN = 4;
   localparam int CB_RXB8 = 1;
   // format c fields
   localparam int FC_PEN = 5;
   localparam int FC_PODD = 4;
   localparam int FC_USBS = 3;
   localparam int FC_SZ_HI = 2;
   localparam int FC_SZ_LO = 1;
   localparam logic [7:0] RST_FORMAT_C = 8'h06;
   localparam logic [7:0] RST_BAUD = 8'h00;
   // sample counts per bit and vote positions
   localparam logic [3:0] SMP_LAST_N = 4'hF;
   localparam logic [3:0] SMP_LAST_D = 4'h7;
   localparam logic [3:0] VOTE_FIRST_N = 4'h8;
   localparam logic [3:0] VOTE_FIRST_D = 4'h4;
   localparam logic [3:0] DATA_BITS_MAX = 4'h9;
   localparam int BUF_DEPTH = 2;
endpackage : urx_pkg

// >>> hw/urx_receiver.sv
// Purpose: serial receiver with two-entry buffer, per-frame flags, start detect
// Assumes: register strobes never both high; read data valid one cycle later
// Notes: baud register sets sample period; sample tick = clocks/(baud+1)
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module urx_receiver
   import urx_pkg::*;
#(
   parameter int DIV_WIDTH = 8
) (
   input  wire logic       CLK,
   input  wire logic       RST_N,
   input  wire logic [2:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   input  wire logic       RXD_PIN,
   output logic            RXD_OVERRIDE,
   output logic            RX_IRQ
);
   typedef enum {URX_IDLE, URX_START, URX_BITS} urx_state_e;

   initial begin
      if (DIV_WIDTH < 1 || DIV_WIDTH > 8) $error("urx_receiver: DIV_WIDTH must be 1..8");
   end

   // majority of three samples
   function automatic logic maj3(input logic [2:0] s);
      maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
   endfunction : maj3

   // software registers
   logic            rx_enable_bit, rx_complete_irq_enable, double_speed_select;
   logic            parity_enable_bit, parity_odd_select, stop_bit_count_select;
   logic [1:0]      char_size;
   logic [7:0]      baud;
   logic            next_en, next_cie, next_u2x, next_pen, next_podd, next_usbs;
   logic [1:0]      next_size;
   logic [7:0]      next_baud;

   // line path
   logic            sync_a, sync_b, line_prev;
   logic            tick;

   // receive engine
   urx_state_e      state, next_state;
   logic [3:0]      smp, next_smp;
   logic [3:0]      bitn, next_bitn;
   logic [2:0]      votes, next_votes;
   logic [8:0]      shreg, next_shreg;
   logic            par_bit, next_par_bit;
   logic            hold, next_hold;
   logic [11:0]     hold_word, next_hold_word;
   logic            lost, next_lost;

   // buffer: {dor, upe, fe, data[8:0]}
   logic [11:0]     mem [BUF_DEPTH];
   logic [11:0]     next_mem [BUF_DEPTH];
   logic [1:0]      cnt, next_cnt;
   logic [7:0]      next_rdata;

   logic [3:0]      smp_last, vote_first, nbits;
   logic            bitval, frame_done, rd_data, push, pop;
   logic [11:0]     frame_word;
   logic [8:0]      dmask;

   urx_sample_div #(.WIDTH(DIV_WIDTH)) u_div (
      .clk     (CLK),
      .rst_n   (RST_N),
      .run     (rx_enable_bit),
      .divisor (baud[DIV_WIDTH-1:0]),
      .tick    (tick)
   );

   // two-flop synchroniser; only sync_b is looked at
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         sync_a    <= 1'b1;
         sync_b    <= 1'b1;
         line_prev <= 1'b1;
      end else begin
         sync_a    <= RXD_PIN;
         sync_b    <= sync_a;
         if (tick) line_prev <= sync_b;
      end
   end

   // register writes
   always_comb begin
      next_en   = rx_enable_bit;
      next_cie  = rx_complete_irq_enable;
      next_u2x  = double_speed_select;
      next_pen  = parity_enable_bit;
      next_podd = parity_odd_select;
      next_usbs = stop_bit_count_select;
      next_size = char_size;
      next_baud = baud;
      if (WR) begin
         case (ADDR)
            ADDR_STATUS_A: next_u2x = WDATA[ST_U2X];   // error flags not writable
            ADDR_CONTROL_B: begin
               next_cie = WDATA[CB_RXCIE];
               next_en  = WDATA[CB_RXEN];
            end
            ADDR_FORMAT_C: begin
               next_pen  = WDATA[FC_PEN];
               next_podd = WDATA[FC_PODD];
               next_usbs = WDATA[FC_USBS];
               next_size = WDATA[FC_SZ_HI:FC_SZ_LO];
            end
            ADDR_BAUD: next_baud = WDATA;
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         rx_enable_bit          <= 1'b0;
         rx_complete_irq_enable <= 1'b0;
         double_speed_select    <= 1'b0;
         parity_enable_bit      <= RST_FORMAT_C[FC_PEN];
         parity_odd_select      <= RST_FORMAT_C[FC_PODD];
         stop_bit_count_select  <= RST_FORMAT_C[FC_USBS];
         char_size              <= RST_FORMAT_C[FC_SZ_HI:FC_SZ_LO];
         baud                   <= RST_BAUD;
      end else begin
         rx_enable_bit          <= next_en;
         rx_complete_irq_enable <= next_cie;
         double_speed_select    <= next_u2x;
         parity_enable_bit      <= next_pen;
         parity_odd_select      <= next_podd;
         stop_bit_count_select  <= next_usbs;
         char_size              <= next_size;
         baud                   <= next_baud;
      end
   end

   // mode-dependent timing; sizes 5..8 data bits
   assign smp_last   = double_speed_select ? SMP_LAST_D : SMP_LAST_N;
   assign vote_first = double_speed_select ? VOTE_FIRST_D : VOTE_FIRST_N;
   assign nbits      = 4'h5 + {2'b00, char_size};
   assign bitval     = maj3({votes[1:0], sync_b});
   assign dmask      = 9'h1FF >> (DATA_BITS_MAX - nbits);
   assign rd_data    = RD && (ADDR == ADDR_DATA);

   // engine: sample counter, start vote, bit shifting
   always_comb begin
      next_state     = state;
      next_smp       = smp;
      next_bitn      = bitn;
      next_votes     = votes;
      next_shreg     = shreg;
      next_par_bit   = par_bit;
      frame_done     = 1'b0;
      frame_word     = '0;
      if (!rx_enable_bit) begin
         next_state = URX_IDLE;
         next_smp   = 4'h0;
      end else if (tick) begin
         case (state)
            URX_IDLE: begin
               next_smp = 4'h0;
               if (line_prev && !sync_b) begin
                  next_state = URX_START;
                  next_smp   = 4'h1;
               end
            end
            URX_START: begin
               next_smp = smp + 4'h1;
               if (smp + 4'h1 >= vote_first && smp + 4'h1 <= vote_first + 4'h1)
                  next_votes = {votes[1:0], sync_b};
               if (smp + 4'h1 == vote_first + 4'h2) begin   // smp lags the sample number by one here
                  if (maj3({votes[1:0], sync_b})) begin
                     next_state = URX_IDLE;
                     next_smp   = 4'h0;
                  end
               end
               if (smp == smp_last) begin
                  next_state = URX_BITS;
                  next_smp   = 4'h1;
                  next_bitn  = 4'h0;
                  next_shreg = '0;
               end
            end
            URX_BITS: begin
               next_smp = (smp == smp_last) ? 4'h0 : smp + 4'h1;   // last sample of a bit shows as 0
               if (smp >= vote_first && smp <= vote_first + 4'h1)
                  next_votes = {votes[1:0], sync_b};
               if (smp == vote_first + 4'h2) begin
                  if (bitn < nbits) begin
                     next_shreg = shreg | ({8'h00, bitval} << bitn);
                     next_bitn  = bitn + 4'h1;
                  end else if (parity_enable_bit && bitn == nbits) begin
                     next_par_bit = bitval;
                     next_bitn    = bitn + 4'h1;
                  end else begin
                     // first stop bit only; a second stop bit is never sampled
                     frame_done = 1'b1;
                     frame_word[8:0] = shreg & dmask;
                     frame_word[9]   = ~bitval;
                     frame_word[10]  = parity_enable_bit &&
                        ((^(shreg & dmask)) ^ par_bit ^ parity_odd_select);
                     next_state = URX_IDLE;
                     next_smp   = 4'h0;
                  end
               end
            end
            default: next_state = URX_IDLE;
         endcase
      end
   end

   // buffer with shifter hold stage and overrun tracking
   always_comb begin
      next_mem       = mem;
      next_cnt       = cnt;
      next_hold      = hold;
      next_hold_word = hold_word;
      next_lost      = lost;
      next_rdata     = 8'h00;
      pop            = rd_data && cnt != 2'd0;
      push           = 1'b0;
      if (pop) begin
         next_mem[0] = mem[1];
         next_cnt    = cnt - 2'd1;
      end
      if (hold && next_cnt < 2'(BUF_DEPTH)) begin
         next_mem[next_cnt[0]] = {lost, hold_word[10:0]};
         next_cnt  = next_cnt + 2'd1;
         next_hold = 1'b0;
         next_lost = 1'b0;
         push      = 1'b1;
      end
      if (tick && state == URX_IDLE && line_prev && !sync_b && next_hold && next_cnt == 2'(BUF_DEPTH))
         next_lost = 1'b1;
      if (frame_done) begin
         if (next_cnt < 2'(BUF_DEPTH)) begin
            next_mem[next_cnt[0]] = {next_lost, frame_word[10:0]};
            next_cnt  = next_cnt + 2'd1;
            next_lost = 1'b0;
         end else if (!next_hold) begin
            next_hold      = 1'b1;
            next_hold_word = frame_word;
         end else begin
            next_lost = 1'b1;
         end
      end
      if (!rx_enable_bit) begin
         next_cnt  = 2'd0;
         next_hold = 1'b0;
         next_lost = 1'b0;
      end
      // read mux; flags come from the head entry
      if (RD) begin
         case (ADDR)
            ADDR_STATUS_A: next_rdata = {cnt != 2'd0, 2'b00, mem[0][9] & (cnt != 2'd0),
                                         mem[0][11] & (cnt != 2'd0), mem[0][10] & (cnt != 2'd0),
                                         double_speed_select, 1'b0};
            ADDR_CONTROL_B: next_rdata = {rx_complete_irq_enable, 2'b00, rx_enable_bit, 2'b00,
                                          mem[0][8] & (cnt != 2'd0), 1'b0};
            ADDR_FORMAT_C: next_rdata = {2'b00, parity_enable_bit, parity_odd_select,
                                         stop_bit_count_select, char_size, 1'b0};
            ADDR_DATA: next_rdata = (cnt != 2'd0) ? mem[0][7:0] : 8'h00;
            ADDR_BAUD: next_rdata = baud;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         state        <= URX_IDLE;
         smp          <= 4'h0;
         bitn         <= 4'h0;
         votes        <= 3'h7;
         shreg        <= '0;
         par_bit      <= 1'b0;
         hold         <= 1'b0;
         hold_word    <= '0;
         lost         <= 1'b0;
         cnt          <= 2'd0;
         mem[0]       <= '0;
         mem[1]       <= '0;
         RDATA        <= 8'h00;
         RXD_OVERRIDE <= 1'b0;
         RX_IRQ       <= 1'b0;
      end else begin
         state        <= next_state;
         smp          <= next_smp;
         bitn         <= next_bitn;
         votes        <= next_votes;
         shreg        <= next_shreg;
         par_bit      <= next_par_bit;
         hold         <= next_hold;
         hold_word    <= next_hold_word;
         lost         <= next_lost;
         cnt          <= next_cnt;
         mem          <= next_mem;
         RDATA        <= next_rdata;
         RXD_OVERRIDE <= next_en;
         // only receive-complete feeds the request
         RX_IRQ       <= next_cie && next_cnt != 2'd0;
      end
   end
endmodule : urx_receiver

// >>> hw/urx_sample_div.sv
// Purpose: baud sample enable divider
// Assumes: divisor held stable while the receiver runs
// Notes: tick every (divisor+1) clocks; restarts when disabled
`timescale 1ns/1ps
module urx_sample_div
   import urx_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             run,
   input  wire logic [WIDTH-1:0] divisor,
   output logic                  tick
);
   logic [WIDTH-1:0] count;
   logic [WIDTH-1:0] next_count;
   logic             next_tick;

   initial begin
      if (WIDTH < 1) $error("urx_sample_div: WIDTH must be positive");
   end

   // count down and pulse at wrap
   always_comb begin
      next_count = count;
      next_tick  = 1'b0;
      if (!run) begin
         next_count = divisor;
      end else if (count == '0) begin
         next_count = divisor;
         next_tick  = 1'b1;
      end else begin
         next_count = count - 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count <= '0;
         tick  <= 1'b0;
      end else begin
         count <= next_count;
         tick  <= next_tick;
      end
   end
endmodule : urx_sample_div

// >>> sim/tb.sv
// Purpose: self-checking bench for the serial receive block
// Assumes: baud register left at zero, so one sample per clock
// Notes: status is always read before data, as software must
`timescale 1ns/1ps
module tb
   import urx_pkg::*;
();
   logic       CLK = 1'b0;
   logic       RST_N = 1'b0;
   logic [2:0] ADDR = 3'h0;
   logic [7:0] WDATA = 8'h00;
   logic       WR = 1'b0;
   logic       RD = 1'b0;
   logic [7:0] RDATA;
   wire        RXD_PIN;
   logic       RXD_OVERRIDE;
   logic       RX_IRQ;
   int         failures = 0;
   int         n_checks = 0;

   // 100 MHz system clock
   always #5 CLK = ~CLK;

   urx_line_model tx (.CLK(CLK), .rxd(RXD_PIN));
   urx_receiver #(.DIV_WIDTH(8)) dut (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .RXD_PIN(RXD_PIN), .RXD_OVERRIDE(RXD_OVERRIDE), .RX_IRQ(RX_IRQ));

   task automatic results();
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one-cycle bus strobes, released at the following edge
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1 d = RDATA;
   endtask : rd

   // write then read with no idle cycle between the strobes
   task automatic wr_rd(input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge CLK);
      ADDR  <= a;
      WDATA <= d;
      WR    <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1 q = RDATA;
   endtask : wr_rd

   // poll status under a bound; running out ends the run
   task automatic wait_rxc();
      logic [7:0] v = 8'h00;
      int         i;
      for (i = 0; i < 400 && v[ST_RXC] !== 1'b1; i++) begin
         rd(ADDR_STATUS_A, v);
      end
      if (v[ST_RXC] !== 1'b1) begin
         failures++;
         results();
      end
   endtask : wait_rxc

   task automatic expect_rx(input logic [7:0] st, input logic [7:0] d);
      logic [7:0] v;
      rd(ADDR_STATUS_A, v);   // status before data
      chk(v & 8'h9E, st);
      rd(ADDR_DATA, v);
      chk(v, d);
   endtask : expect_rx

   task automatic t_regs();
      logic [7:0] v;
      rd(ADDR_FORMAT_C, v);
      chk(v, RST_FORMAT_C);
      rd(ADDR_BAUD, v);
      chk(v, RST_BAUD);
      rd(ADDR_STATUS_A, v);
      chk(v & 8'h9E, 8'h00);
      rd(3'h5, v);
      chk(v, 8'h00);
   endtask : t_regs

   task automatic t_basic();
      logic [7:0] v;
      wr(ADDR_CONTROL_B, 8'h90);
      tx.send(8'hA5, 8, 0, 0, 1, 16);
      wait_rxc();
      chk({7'h00, RX_IRQ}, 8'h01);
      expect_rx(8'h80, 8'hA5);
      repeat (3) @(posedge CLK);
      #1 chk({7'h00, RX_IRQ}, 8'h00);
      rd(ADDR_STATUS_A, v);
      chk(v & 8'h80, 8'h00);
   endtask : t_basic

   // bad stop bit with irq disabled; status write must not touch flags
   task automatic t_ferr();
      logic [7:0] v;
      int         i;
      wr(ADDR_CONTROL_B, 8'h10);
      tx.send(8'h3C, 8, 0, 0, 0, 16);
      wait_rxc();
      chk({7'h00, RX_IRQ}, 8'h00);
      wr_rd(ADDR_STATUS_A, 8'h00, v);
      chk(v & 8'h9E, 8'h90);
      expect_rx(8'h90, 8'h3C);
      for (i = 0; i < 3; i++) begin
         rd(ADDR_STATUS_A, v);
         if (v[ST_RXC] === 1'b1) begin
            rd(ADDR_DATA, v);
         end
      end
      wr(ADDR_CONTROL_B, 8'h90);
   endtask : t_ferr

   // even and odd checking, each with a good and a bad parity bit
   task automatic t_parity();
      logic [7:0] d = 8'h6B;
      int         m;
      int         bad;
      for (m = 0; m < 2; m++) begin
         wr(ADDR_FORMAT_C, 8'h26 | 8'(m << 4));
         for (bad = 0; bad < 2; bad++) begin
            tx.send(d, 8, 1, (^d) ^ m[0] ^ bad[0], 1, 16);
            wait_rxc();
            expect_rx(bad ? 8'h84 : 8'h80, d);
         end
      end
      // five data bits with two stop bits selected: upper bits read as zero
      wr(ADDR_FORMAT_C, 8'h08);
      tx.send(8'hF5, 5, 0, 0, 1, 16);
      wait_rxc();
      expect_rx(8'h80, 8'h15);
      wr(ADDR_FORMAT_C, 8'h06);
   endtask : t_parity

   // four frames with no reads: buffer full, one waiting, one lost
   task automatic t_overrun();
      logic [7:0] v;
      logic       dor = 1'b0;
      int         i;
      for (i = 1; i < 5; i++) begin
         tx.send(8'(8'h11 * i), 8, 0, 0, 1, 16);
      end
      for (i = 0; i < 4; i++) begin
         rd(ADDR_STATUS_A, v);
         if (v[ST_RXC] === 1'b1) begin
            dor = dor | v[ST_DOR];
            rd(ADDR_DATA, v);
            if (i < 3) chk(v, 8'(8'h11 * (i + 1)));
         end
      end
      chk({7'h00, dor}, 8'h01);
      rd(ADDR_STATUS_A, v);
      chk(v & 8'h80, 8'h00);
      tx.send(8'h55, 8, 0, 0, 1, 16);
      wait_rxc();
      expect_rx(8'h80, 8'h55);
   endtask : t_overrun

   // double speed frame, then a rejected spike followed by a real frame
   task automatic t_speed_glitch();
      logic [7:0] v;
      wr_rd(ADDR_STATUS_A, 8'h02, v);
      chk(v & 8'h9E, 8'h02);
      tx.send(8'h5A, 8, 0, 0, 1, 8);
      wait_rxc();
      expect_rx(8'h82, 8'h5A);
      wr(ADDR_STATUS_A, 8'h00);
      tx.glitch(3);
      // long enough for a wrongly accepted spike to land as a frame
      repeat (180) @(posedge CLK);
      rd(ADDR_STATUS_A, v);
      chk(v & 8'h80, 8'h00);
      chk({7'h00, RX_IRQ}, 8'h00);
      tx.send(8'h96, 8, 0, 0, 1, 16);
      wait_rxc();
      expect_rx(8'h80, 8'h96);
   endtask : t_speed_glitch

   // disabling flushes the buffer and drops a frame in flight
   task automatic t_disable();
      logic [7:0] v;
      tx.send(8'hE1, 8, 0, 0, 1, 16);
      wait_rxc();
      wr(ADDR_CONTROL_B, 8'h80);
      @(posedge CLK);
      #1 chk({6'h00, RXD_OVERRIDE, RX_IRQ}, 8'h00);
      rd(ADDR_STATUS_A, v);
      chk(v & 8'h80, 8'h00);
      wr(ADDR_CONTROL_B, 8'h90);
      // short off pulse once the line stays high to the frame's end: a receiver that
      // kept running would still finish the frame, and no new start can be seen
      fork
         tx.send(8'hC3, 8, 0, 0, 1, 16);
         begin
            repeat (116) @(posedge CLK);
            wr(ADDR_CONTROL_B, 8'h80);
            wr(ADDR_CONTROL_B, 8'h90);
         end
      join
      repeat (20) @(posedge CLK);
      rd(ADDR_STATUS_A, v);
      chk(v & 8'h80, 8'h00);
      chk({7'h00, RXD_OVERRIDE}, 8'h01);
   endtask : t_disable

   // reset, then every scenario in turn
   initial begin
      repeat (16) @(posedge CLK);
      RST_N <= 1'b1;
      t_regs();
      t_basic();
      t_ferr();
      t_parity();
      t_overrun();
      t_speed_glitch();
      t_disable();
      results();
   end
endmodule : tb

// >>> sim/urx_chk.sv
// Purpose: port-level assertions for the serial receive block
// Assumes: baud, mode and control fields are written only while the line is idle
// Notes: bound to every receiver instance; pin ownership lags a write by one edge, irq by up to two
`timescale 1ns/1ps
module urx_chk
   import urx_pkg::*;
(
   input wire logic       CLK,
   input wire logic       RST_N,
   input wire logic [2:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic       WR,
   input wire logic       RD,
   input wire logic [7:0] RDATA,
   input wire logic       RXD_PIN,
   input wire logic       RXD_OVERRIDE,
   input wire logic       RX_IRQ
);
   default clocking dc @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   // bus steps named for p_ovr and a_speed_rw, one sequence each
   sequence s_ctl_wr;
      WR && ADDR == ADDR_CONTROL_B;
   endsequence
   sequence s_st_wr_rd;
      WR && ADDR == ADDR_STATUS_A ##1 RD && ADDR == ADDR_STATUS_A;
   endsequence

   // pin ownership follows the written enable bit
   property p_ovr;
      s_ctl_wr |-> ##2 RXD_OVERRIDE == $past(WDATA[CB_RXEN], 2);
   endproperty

   a_rdata_quiet: assert property (!RD |=> RDATA == 8'h00)
      else $error("read data not zero outside a read answer");
   a_unmapped_zero: assert property (RD && ADDR > ADDR_BAUD |=> RDATA == 8'h00)
      else $error("unmapped read returned nonzero");
   a_pin_owner: assert property (p_ovr)
      else $error("pin ownership does not follow receiver enable");
   a_irq_drop: assert property (WR && ADDR == ADDR_CONTROL_B && !(WDATA[CB_RXCIE] && WDATA[CB_RXEN])
                                |-> ##2 !RX_IRQ)
      else $error("irq still high after enable or receiver cleared");
   a_irq_needs_rx: assert property ($rose(RX_IRQ) |-> RXD_OVERRIDE)
      else $error("irq rose with receiver disabled");
   a_irq_holds: assert property (RX_IRQ && !RD && !WR && !$past(RD) && !$past(WR) |=> RX_IRQ)
      else $error("irq fell without a data read");
   a_speed_rw: assert property (s_st_wr_rd |=> RDATA[ST_U2X] == $past(WDATA[ST_U2X], 2))
      else $error("double speed bit did not read back");
   a_off_quiet: assert property (!RXD_OVERRIDE [*3] |-> !RX_IRQ)
      else $error("irq high while receiver disabled");
endmodule : urx_chk

bind urx_receiver urx_chk u_chk (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
   .RDATA(RDATA), .RXD_PIN(RXD_PIN), .RXD_OVERRIDE(RXD_OVERRIDE), .RX_IRQ(RX_IRQ));

// >>> sim/urx_line_model.sv
// Purpose: remote serial transmitter driving the receive line
// Assumes: bit length given in system clocks; line idles high
// Notes: changes the line only just after a rising clock edge
`timescale 1ns/1ps
module urx_line_model (
   input wire logic CLK,
   output logic     rxd
);
   initial rxd = 1'b1;

   // hold one level for n clocks
   task automatic put(input logic v, input int n);
      @(posedge CLK);
      rxd <= v;
      repeat (n - 1) @(posedge CLK);
   endtask : put

   // start, lsb-first data, optional parity, one stop, then a bit of idle
   task automatic send(input logic [7:0] d, input int nb, input bit pe, input bit pb, input bit sb, input int bc);
      int i;
      put(1'b0, bc);
      for (i = 0; i < nb; i++) begin
         put(d[i], bc);
      end
      if (pe) begin
         put(pb, bc);
      end
      put(sb, bc);
      put(1'b1, bc);   // idle gap so the next start has a clean falling edge
   endtask : send

   // short low spike, too brief to survive the start vote
   task automatic glitch(input int n);
      put(1'b0, n);
      put(1'b1, 16);
   endtask : glitch
endmodule : urx_line_model
